// ---- common/plc_pkg.sv ----
package plc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses and reset values
  localparam logic [15:0] ADDR_CTRL_ONE   = 16'h001b;
  localparam logic [15:0] ADDR_CTRL_TWO   = 16'h001c;
  localparam logic [15:0] ADDR_CTRL_THREE = 16'h001d;
  localparam logic [15:0] ADDR_USER_STR   = 16'hbc00;

  localparam logic [15:0] RST_CTRL_ONE    = 16'h0001;
  localparam logic [15:0] RST_CTRL_TWO    = 16'h210a;
  localparam logic [15:0] RST_CTRL_THREE  = 16'h1855;
  localparam logic [15:0] RST_USER_STR    = 16'h0000;

  // writable bits; the rest read as zero
  localparam logic [15:0] WMASK_CTRL_ONE   = 16'hfcff;
  localparam logic [15:0] WMASK_CTRL_TWO   = 16'hffff;
  localparam logic [15:0] WMASK_CTRL_THREE = 16'h3fff;
  localparam logic [15:0] WMASK_USER_STR   = 16'h003f;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int EXT_SET_BIT   = 10;
  localparam int HOLD_LSB      = 4;
  localparam int HOLD_W        = 4;
  localparam int SEL_LSB       = 2;
  localparam int SEL_W         = 2;
  localparam int OUT_DIS_BIT   = 1;
  localparam int STR_EN_BIT    = 0;
  localparam int FUNC_LOW_LSB  = 0;
  localparam int FUNC_LOW_W    = 4;
  localparam int PAT_LSB       = 0;
  localparam int PAT_W         = 8;
  localparam int TICK_LSB      = 8;
  localparam int TICK_W        = 6;
  localparam int USER_STR_W    = 6;

  localparam logic [1:0] SEL_32MS  = 2'h0;
  localparam logic [1:0] SEL_64MS  = 2'h1;
  localparam logic [1:0] SEL_102MS = 2'h2;
  localparam logic [1:0] SEL_USER  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned STR_A_MS        = 32;
  localparam int unsigned STR_B_MS        = 64;
  localparam int unsigned STR_C_MS        = 102;
  localparam int unsigned BLINK_HALF_MS   = 500;
  localparam int unsigned DEFAULT_TICKS   = 24;
  localparam int unsigned USER_UNIT_MS    = 1;
  // one tick unit so the default pattern gives half-second bits
  localparam int unsigned TICK_UNIT_CYC_D = BLINK_HALF_MS * CYC_PER_MS / DEFAULT_TICKS;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic link_up;
    logic link_100;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
  } plc_status_s;

  typedef enum logic [1:0] {
    PAT_SHIFT = 2'b01,
    PAT_HOLD  = 2'b10
  } plc_pat_e;

endpackage

// ---- rtl/plc_stretch.sv ----
`timescale 1ns/1ps
module plc_stretch (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        event_in,
  input  wire logic [31:0] duration,
  output logic             stretched_q
);

  logic [31:0] cnt_q;

  // count restarts on every active cycle, so a busy line stays lit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (event_in) begin
      cnt_q <= duration;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stretched_q <= 1'b0;
    end else begin
      stretched_q <= event_in | (enable & (cnt_q != '0));
    end
  end

  property p_stretch_holds;
    @(posedge clock) disable iff (!rst_n)
      enable && event_in ##1 !event_in && enable && cnt_q > 32'h1 |=> stretched_q;
  endproperty
  a_stretch_holds: assert property (p_stretch_holds) else $error("stretch dropped early");

  property p_no_stretch;
    @(posedge clock) disable iff (!rst_n)
      !enable ##1 !enable |-> stretched_q == $past(event_in);
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stretch while disabled");

endmodule // plc_stretch

// ---- rtl/plc_led.sv ----
`timescale 1ns/1ps
// Contract
// - bit 10 of control one enables the extended function set
// - function code is extended bit over four low bits; default on-link blink-activity
// - after the pattern, last bit held for bit time times hold multiplier
// - default pattern blinks half a second on, half a second off
// - stretch select 0,1,2 give 32, 64, 102 ms; 3 uses user time
// - select 3 takes stretch time from six-bit user register at 0xbc00
// - bit 1 high disables indicator outputs; reset leaves them enabled
// - bit 0 stretches transmit, receive, collision indications; resets to one
module plc_led #(
  parameter int unsigned TICK_UNIT_CYC = plc_pkg::TICK_UNIT_CYC_D,
  parameter int unsigned STR_A_CYC     = plc_pkg::STR_A_MS * plc_pkg::CYC_PER_MS,
  parameter int unsigned STR_B_CYC     = plc_pkg::STR_B_MS * plc_pkg::CYC_PER_MS,
  parameter int unsigned STR_C_CYC     = plc_pkg::STR_C_MS * plc_pkg::CYC_PER_MS,
  parameter int unsigned USER_UNIT_CYC = plc_pkg::USER_UNIT_MS * plc_pkg::CYC_PER_MS
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 reg_wr,
  input  wire logic [15:0]          reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire plc_pkg::plc_status_s status,
  output logic      [15:0]          reg_rdata_q,
  output logic                      indicator_pin_q
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: products below must fit 32 bits
  if (TICK_UNIT_CYC == 0 || TICK_UNIT_CYC > 32'h03ff_ffff) begin : g_chk_tick
    $error("TICK_UNIT_CYC out of range");
  end
  if (STR_A_CYC == 0 || STR_B_CYC == 0 || STR_C_CYC == 0) begin : g_chk_str
    $error("stretch counts must be nonzero");
  end
  if (USER_UNIT_CYC == 0 || USER_UNIT_CYC > 32'h03ff_ffff) begin : g_chk_user
    $error("USER_UNIT_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] led_control_one_q;
  logic [15:0] led_control_two_q;
  logic [15:0] led_control_three_q;
  logic [15:0] user_stretch_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      led_control_one_q   <= plc_pkg::RST_CTRL_ONE;
      led_control_two_q   <= plc_pkg::RST_CTRL_TWO;
      led_control_three_q <= plc_pkg::RST_CTRL_THREE;
      user_stretch_q      <= plc_pkg::RST_USER_STR;
    end else if (reg_wr) begin
      case (reg_addr)
        plc_pkg::ADDR_CTRL_ONE:   led_control_one_q   <= reg_wdata & plc_pkg::WMASK_CTRL_ONE;
        plc_pkg::ADDR_CTRL_TWO:   led_control_two_q   <= reg_wdata & plc_pkg::WMASK_CTRL_TWO;
        plc_pkg::ADDR_CTRL_THREE: led_control_three_q <= reg_wdata & plc_pkg::WMASK_CTRL_THREE;
        plc_pkg::ADDR_USER_STR:   user_stretch_q      <= reg_wdata & plc_pkg::WMASK_USER_STR;
        default: ;
      endcase
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else begin
      case (reg_addr)
        plc_pkg::ADDR_CTRL_ONE:   reg_rdata_q <= led_control_one_q;
        plc_pkg::ADDR_CTRL_TWO:   reg_rdata_q <= led_control_two_q;
        plc_pkg::ADDR_CTRL_THREE: reg_rdata_q <= led_control_three_q;
        plc_pkg::ADDR_USER_STR:   reg_rdata_q <= user_stretch_q;
        default:                  reg_rdata_q <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views
  logic                            led_extended_set_enable;
  logic [plc_pkg::HOLD_W-1:0]      pattern_hold_multiplier;
  logic [plc_pkg::SEL_W-1:0]       stretch_time_select;
  logic                            indicator_output_disable;
  logic                            event_stretch_enable;
  logic [plc_pkg::FUNC_LOW_W-1:0]  indicator_function_low_bits;
  logic [plc_pkg::PAT_W-1:0]       blink_pattern_bits;
  logic [plc_pkg::TICK_W-1:0]      pattern_bit_time;
  logic [plc_pkg::USER_STR_W-1:0]  user_stretch_time;
  logic [4:0]                      func_code;

  assign led_extended_set_enable     = led_control_one_q[plc_pkg::EXT_SET_BIT];
  assign pattern_hold_multiplier     = led_control_one_q[plc_pkg::HOLD_LSB +: plc_pkg::HOLD_W];
  assign stretch_time_select         = led_control_one_q[plc_pkg::SEL_LSB +: plc_pkg::SEL_W];
  assign indicator_output_disable    = led_control_one_q[plc_pkg::OUT_DIS_BIT];
  assign event_stretch_enable        = led_control_one_q[plc_pkg::STR_EN_BIT];
  assign indicator_function_low_bits =
    led_control_two_q[plc_pkg::FUNC_LOW_LSB +: plc_pkg::FUNC_LOW_W];
  assign blink_pattern_bits          = led_control_three_q[plc_pkg::PAT_LSB +: plc_pkg::PAT_W];
  assign pattern_bit_time            = led_control_three_q[plc_pkg::TICK_LSB +: plc_pkg::TICK_W];
  assign user_stretch_time           = user_stretch_q[plc_pkg::USER_STR_W-1:0];
  assign func_code = {led_extended_set_enable, indicator_function_low_bits};

  ////////////////////////////////////////////////////////////////////////////
  // event stretching
  logic [31:0] stretch_cyc;
  logic [2:0]  raw_evt;
  logic [2:0]  str_evt;

  always_comb begin
    case (stretch_time_select)
      plc_pkg::SEL_32MS:  stretch_cyc = STR_A_CYC;
      plc_pkg::SEL_64MS:  stretch_cyc = STR_B_CYC;
      plc_pkg::SEL_102MS: stretch_cyc = STR_C_CYC;
      default:            stretch_cyc = 32'(user_stretch_time) * USER_UNIT_CYC;
    endcase
  end

  assign raw_evt = {status.tx_active, status.rx_active, status.collision};

  // stretchers run regardless of the output disable, so re-enable resumes
  for (genvar i = 0; i < 3; i++) begin : g_str
    plc_stretch u_str (
      .clock       (clock),
      .rst_n       (rst_n),
      .enable      (event_stretch_enable),
      .event_in    (raw_evt[i]),
      .duration    (stretch_cyc),
      .stretched_q (str_evt[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink pattern engine
  plc_pkg::plc_pat_e pat_state_q;
  logic [31:0]       tick_cnt_q;
  logic [31:0]       tick_len;
  logic [2:0]        bit_idx_q;
  logic [plc_pkg::HOLD_W-1:0] hold_cnt_q;
  logic              tick_end;
  logic              blink_bit;

  // a zero bit time would stall the engine, so it counts as one unit
  assign tick_len  = (pattern_bit_time == '0) ? TICK_UNIT_CYC
                   : 32'(pattern_bit_time) * TICK_UNIT_CYC;
  assign tick_end  = (tick_cnt_q >= tick_len - 32'h1);
  assign blink_bit = blink_pattern_bits[bit_idx_q];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (tick_end) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pat_state_q <= plc_pkg::PAT_SHIFT;
      bit_idx_q   <= '0;
      hold_cnt_q  <= '0;
    end else if (tick_end) begin
      case (pat_state_q)
        plc_pkg::PAT_SHIFT: begin
          if (bit_idx_q == 3'(plc_pkg::PAT_W - 1)) begin
            if (pattern_hold_multiplier != '0) begin
              pat_state_q <= plc_pkg::PAT_HOLD;
              hold_cnt_q  <= '0;
            end else begin
              bit_idx_q <= '0;
            end
          end else begin
            bit_idx_q <= bit_idx_q + 3'h1;
          end
        end
        plc_pkg::PAT_HOLD: begin
          // bit index stays on the last bit while holding
          if (hold_cnt_q + 4'h1 >= pattern_hold_multiplier) begin
            pat_state_q <= plc_pkg::PAT_SHIFT;
            bit_idx_q   <= '0;
          end else begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end
        end
        default: begin
          pat_state_q <= plc_pkg::PAT_SHIFT;
          bit_idx_q   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // function decode
  logic act;
  logic led_on;

  assign act = str_evt[2] | str_evt[1];

  always_comb begin
    case (func_code)
      5'h1f:   led_on = status.link_up & (status.link_100 ? blink_bit : 1'b1);
      5'h1d:   led_on = status.link_up & (status.link_100 ? 1'b1 : blink_bit);
      5'h1c:   led_on = status.link_up & status.link_100;
      5'h1b:   led_on = status.link_up & !status.link_100 & blink_bit;
      5'h1a:   led_on = str_evt[2] & blink_bit;
      5'h19:   led_on = act & blink_bit;
      5'h13:   led_on = status.link_up & status.link_100 & (act ? blink_bit : 1'b1);
      5'h12:   led_on = status.link_up & !status.link_100 & (act ? blink_bit : 1'b1);
      5'h10:   led_on = status.link_up;
      5'h0f:   led_on = 1'b0;
      5'h0e:   led_on = 1'b1;
      5'h0d:   led_on = blink_bit;
      5'h0c:   led_on = status.link_up & status.full_duplex & (str_evt[0] ? blink_bit : 1'b1);
      5'h0b:   led_on = status.link_up & (str_evt[1] ? blink_bit : 1'b1);
      5'h0a:   led_on = status.link_up & (act ? blink_bit : 1'b1);
      5'h09:   led_on = str_evt[0];
      5'h08:   led_on = status.link_up & status.full_duplex;
      5'h07:   led_on = act;
      5'h06:   led_on = str_evt[1];
      5'h05:   led_on = str_evt[2];
      5'h04:   led_on = status.link_up;
      5'h03:   led_on = status.link_up & status.link_100 & blink_bit;
      default: led_on = 1'b0;
    endcase
  end

  // pin is driven low while outputs are disabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      indicator_pin_q <= 1'b0;
    end else begin
      indicator_pin_q <= led_on & !indicator_output_disable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ext_write;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && reg_addr == plc_pkg::ADDR_CTRL_ONE
      |=> led_extended_set_enable == $past(reg_wdata[plc_pkg::EXT_SET_BIT]);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("extended bit not stored");

  property p_code_off;
    @(posedge clock) disable iff (!rst_n)
      func_code == 5'h0f ##1 func_code == 5'h0f |=> !indicator_pin_q;
  endproperty
  a_code_off: assert property (p_code_off) else $error("off code lit pin");

  property p_hold_last;
    @(posedge clock) disable iff (!rst_n)
      pat_state_q == plc_pkg::PAT_HOLD |-> bit_idx_q == 3'(plc_pkg::PAT_W - 1);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("hold not on last bit");

  property p_hold_entry;
    @(posedge clock) disable iff (!rst_n)
      $rose(pat_state_q == plc_pkg::PAT_HOLD) |-> $past(pattern_hold_multiplier) != '0;
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("hold with zero multiplier");

  property p_sel_fixed;
    @(posedge clock) disable iff (!rst_n)
      stretch_time_select == plc_pkg::SEL_64MS |-> stretch_cyc == STR_B_CYC;
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("wrong 64 ms count");

  property p_sel_user;
    @(posedge clock) disable iff (!rst_n)
      stretch_time_select == plc_pkg::SEL_USER
      |-> stretch_cyc == 32'(user_stretch_time) * USER_UNIT_CYC;
  endproperty
  a_sel_user: assert property (p_sel_user) else $error("user stretch count wrong");

  property p_disabled_low;
    @(posedge clock) disable iff (!rst_n)
      indicator_output_disable |=> !indicator_pin_q;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("pin lit while disabled");

  property p_timer_runs;
    @(posedge clock) disable iff (!rst_n)
      indicator_output_disable && !tick_end |=> tick_cnt_q == $past(tick_cnt_q) + 32'h1;
  endproperty
  a_timer_runs: assert property (p_timer_runs) else $error("timer stopped when disabled");

endmodule // plc_led

// ---- testbench/plc_indicator_model.sv ----
`timescale 1ns/1ps
// indicator lamp seen from the pin: remembers how long the last lit and dark runs lasted, and the longest dark run
module plc_indicator_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        pin,
  output logic      [15:0] on_len_q,
  output logic      [15:0] off_len_q,
  output logic      [15:0] off_max_q
);
  logic [15:0] run_q;
  logic        last_q;

  ////////////////////////////////////////////////////////////////////////////
  // run lengths; a run is stored only when it ends, so a partial run is never seen
  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      run_q     <= 16'h0000;
      last_q    <= 1'b0;
      on_len_q  <= 16'h0000;
      off_len_q <= 16'h0000;
      off_max_q <= 16'h0000;
    end else begin
      last_q <= pin;
      if (pin == last_q) begin
        run_q <= run_q + 16'h0001;
      end else begin
        run_q <= 16'h0001;
        if (last_q) begin
          on_len_q <= run_q;
        end else begin
          off_len_q <= run_q;
          if (run_q > off_max_q) begin
            off_max_q <= run_q;
          end
        end
      end
    end
  end
endmodule // plc_indicator_model

// ---- testbench/phy_led_control_bench.sv ----
`timescale 1ns/1ps
module phy_led_control_bench;
  // short counts keep the run small; every timing expectation is derived from these
  localparam int unsigned TU = 2;
  localparam int unsigned SA = 3;
  localparam int unsigned SB = 5;
  localparam int unsigned SC = 7;
  localparam int unsigned UU = 2;

  logic                 clock;
  logic                 rst_n;
  logic                 reg_wr;
  logic [15:0]          reg_addr;
  logic [15:0]          reg_wdata;
  plc_pkg::plc_status_s status;
  logic [15:0]          rdata;
  logic                 pin;
  logic                 clear;
  logic [15:0]          on_len;
  logic [15:0]          off_len;
  logic [15:0]          off_max;
  int                   fail_count;
  int                   total_checks;

  plc_led #(.TICK_UNIT_CYC(TU), .STR_A_CYC(SA), .STR_B_CYC(SB), .STR_C_CYC(SC),
            .USER_UNIT_CYC(UU)) i_dut (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .status(status), .reg_rdata_q(rdata), .indicator_pin_q(pin));

  plc_indicator_model i_lamp (
    .clock(clock), .rst_n(rst_n), .clear(clear), .pin(pin),
    .on_len_q(on_len), .off_len_q(off_len), .off_max_q(off_max));

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr    = 1'b0;
  endtask

  task automatic rd_check(input string what, input logic [15:0] a, input logic [15:0] exp);
    @(negedge clock);
    reg_addr = a;
    repeat (2) @(negedge clock);
    check(what, exp, rdata);
  endtask

  task automatic settle();
    repeat (2) @(negedge clock);
  endtask

  task automatic clear_lamp();
    @(negedge clock);
    clear = 1'b1;
    @(negedge clock);
    clear = 1'b0;
  endtask

  task automatic wait_level(input logic lvl, input int bound);
    int n;
    n = 0;
    while (pin !== lvl && n < bound) begin
      @(negedge clock);
      n++;
    end
    if (pin !== lvl) begin
      fail_count++;
      $display("Error pin wait expected %b seen %b", lvl, pin);
      results();
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd_check("ctrl one reset", plc_pkg::ADDR_CTRL_ONE, 16'h0001);
    rd_check("ctrl two reset", plc_pkg::ADDR_CTRL_TWO, 16'h210a);
    rd_check("ctrl three reset", plc_pkg::ADDR_CTRL_THREE, 16'h1855);
    rd_check("user time reset", plc_pkg::ADDR_USER_STR, 16'h0000);
    rd_check("unmapped read", 16'h0020, 16'h0000);
    status.link_up = 1'b1;
    settle();
    check("default code lit on link", 16'h0001, {15'h0000, pin});
  endtask

  task automatic t_masks();
    wr(plc_pkg::ADDR_CTRL_ONE, 16'hffff);
    rd_check("ctrl one mask", plc_pkg::ADDR_CTRL_ONE, 16'hfcff);
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0001);
    wr(plc_pkg::ADDR_USER_STR, 16'hffff);
    rd_check("user time mask", plc_pkg::ADDR_USER_STR, 16'h003f);
    wr(16'h0020, 16'hffff);
    rd_check("unmapped write", 16'h0020, 16'h0000);
  endtask

  task automatic t_ext();
    wr(plc_pkg::ADDR_CTRL_TWO, 16'h0000);
    settle();
    check("code 00000 off", 16'h0000, {15'h0000, pin});
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0401);
    settle();
    check("code 10000 on link", 16'h0001, {15'h0000, pin});
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0001);
  endtask

  task automatic t_disable();
    wr(plc_pkg::ADDR_CTRL_TWO, 16'h000e);
    settle();
    check("code on lit", 16'h0001, {15'h0000, pin});
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0003);
    settle();
    check("disabled pin", 16'h0000, {15'h0000, pin});
    repeat (20) @(negedge clock);
    check("disabled pin held", 16'h0000, {15'h0000, pin});
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0001);
    settle();
    check("re-enabled pin", 16'h0001, {15'h0000, pin});
  endtask

  task automatic t_stretch();
    logic [15:0] code [7];
    logic [15:0] ctrl [7];
    int          ev   [7];
    int          exp  [7];
    code = '{16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0007, 16'h0009};
    ctrl = '{16'h0001, 16'h0005, 16'h0009, 16'h000d, 16'h0000, 16'h0001, 16'h0001};
    ev   = '{2, 2, 2, 2, 2, 1, 0};
    exp  = '{SA + 1, SB + 1, SC + 1, 3 * UU + 1, 1, SA + 1, SA + 1};
    wr(plc_pkg::ADDR_USER_STR, 16'h0003);
    for (int s = 0; s < 7; s++) begin
      wr(plc_pkg::ADDR_CTRL_TWO, code[s]);
      wr(plc_pkg::ADDR_CTRL_ONE, ctrl[s]);
      settle();
      clear_lamp();
      @(negedge clock);
      status[ev[s]] = 1'b1;
      @(negedge clock);
      status[ev[s]] = 1'b0;
      wait_level(1'b1, 20);
      wait_level(1'b0, 100);
      @(negedge clock);
      check("stretch width", 16'(exp[s]), on_len);
    end
  endtask

  task automatic t_pattern();
    wr(plc_pkg::ADDR_CTRL_TWO, 16'h000d);
    wr(plc_pkg::ADDR_CTRL_THREE, 16'h1855);
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0001);
    clear_lamp();
    repeat (700) @(negedge clock);
    check("default on time", 16'(24 * TU), on_len);
    check("default off time", 16'(24 * TU), off_len);
    wr(plc_pkg::ADDR_CTRL_THREE, 16'h0255);
    wr(plc_pkg::ADDR_CTRL_ONE, 16'h0031);
    clear_lamp();
    repeat (200) @(negedge clock);
    check("bit time", 16'(2 * TU), on_len);
    check("held last bit", 16'(2 * TU * 4), off_max);
  endtask

  // steady levels only; an all-ones or all-zeros pattern pins the blink bit
  task automatic t_codes();
    logic [4:0] code [17];
    logic [5:0] st   [17];
    int         pb   [17];
    int         ex   [17];
    code = '{5'h1f, 5'h1f, 5'h1d, 5'h1c, 5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h13, 5'h12,
             5'h0f, 5'h0c, 5'h0b, 5'h08, 5'h08, 5'h04, 5'h03};
    st   = '{6'h20, 6'h30, 6'h30, 6'h20, 6'h30, 6'h20, 6'h04, 6'h02, 6'h30, 6'h20,
             6'h20, 6'h29, 6'h22, 6'h28, 6'h20, 6'h00, 6'h30};
    pb   = '{0, 0, 0, 1, 0, 1, 1, 1, 0, 0, 1, 0, 0, 0, 1, 1, 1};
    ex   = '{1, 0, 1, 0, 1, 1, 1, 1, 1, 1, 0, 0, 0, 1, 0, 0, 1};
    for (int s = 0; s < 17; s++) begin
      status = plc_pkg::plc_status_s'(st[s]);
      wr(plc_pkg::ADDR_CTRL_THREE, (pb[s] != 0) ? 16'h00ff : 16'h0000);
      wr(plc_pkg::ADDR_CTRL_TWO, {12'h000, code[s][3:0]});
      wr(plc_pkg::ADDR_CTRL_ONE, {5'h00, code[s][4], 10'h001});
      settle();
      check("function code pin", 16'(ex[s]), {15'h0000, pin});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clock        = 1'b0;
    rst_n        = 1'b0;
    reg_wr       = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 16'h0000;
    status       = '0;
    clear        = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_ext();
    t_disable();
    t_stretch();
    t_pattern();
    t_codes();
    results();
  end
endmodule // phy_led_control_bench
